// ---- common/smp_pkg.sv ----
// smp_pkg: constants and carrier types of the serial modem port
// Operation
// - control writes except baud keep low byte, ignore rest; baud uses all 16 bits
// - reset or power-up restores every default
// - ident fixed code, top bit jumper absent
// - nonzero reset write resets, aborts, flushes
// - irq bit7 enabled, bit6 requesting, 3:0 zero
// - nonzero break write sends a break
// - activity bit3 escape error, 7:4 zero
// - activity bits handshake, firmware irq, transfer
// - baud readback always a standard rate
// - baud 25..28800 rounded, else error
// - format 7:6 keep, xon/xoff, unsupported, off
// - format 5:4 odd or even parity
// - format bit3 enables parity send
// - format bit2 selects one or two stops
// - format 1:0 select five to eight bits
// - drive data terminal ready to modem
// - drive secondary request to send
// - drive data rate select output
// - supply transmit clock toward modem
package smp_pkg;
  localparam int unsigned CLK_HZ_DEF = 200_000_000;
  localparam int DIV_W = 22;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] REG_IDENT_RST = 4'h0;
  localparam logic [3:0] REG_IRQ_BRK = 4'h1;
  localparam logic [3:0] REG_ACT = 4'h2;
  localparam logic [3:0] REG_BAUD = 4'h3;
  localparam logic [3:0] REG_FMT = 4'h4;
  // arbitrary value, bit 7 kept clear for the jumper flag
  localparam logic [6:0] IDENT_CODE = 7'h3A;
  localparam int IDENT_JMP_BIT = 7;
  localparam int IRQ_EN_BIT = 7;
  localparam int IRQ_REQ_BIT = 6;
  localparam int IRQ_LVL_LSB = 4;
  localparam int ACT_ESC_BIT = 3;
  localparam int ACT_HS_BIT = 2;
  localparam int ACT_ARM_BIT = 1;
  localparam int ACT_XFER_BIT = 0;
  localparam int FMT_HS_LSB = 6;
  localparam int FMT_SENSE_LSB = 4;
  localparam int FMT_PEN_BIT = 3;
  localparam int FMT_STOP_BIT = 2;
  localparam int FMT_LEN_LSB = 0;
  localparam logic [7:0] FMT_RST = 8'hC3;
  localparam logic [3:0] BAUD_IDX_RST = 4'hE;
  localparam logic [15:0] BAUD_MIN = 16'h0019;
  localparam logic [15:0] BAUD_MAX = 16'h7080;
  localparam logic [1:0] HS_KEEP = 2'h0;
  localparam logic [1:0] HS_XON = 2'h1;
  localparam logic [1:0] HS_BAD = 2'h2;
  localparam logic [1:0] HS_OFF = 2'h3;
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [3:0] LEN_MIN = 4'h5;
  localparam logic [3:0] BRK_BITS = 4'hD;
  localparam logic [3:0] DRS_IDX = 4'hA;
  localparam logic [15:0] RATE [16] = '{16'h0032, 16'h004B, 16'h006E, 16'h0086,
    16'h0096, 16'h00C8, 16'h012C, 16'h0258, 16'h04B0, 16'h0708, 16'h0960,
    16'h0E10, 16'h12C0, 16'h1C20, 16'h2580, 16'h4B00};
  // midpoints between neighbouring rates, for rounding to nearest
  localparam logic [15:0] RATE_MID [15] = '{16'h003F, 16'h005D, 16'h007A,
    16'h008E, 16'h00AF, 16'h00FA, 16'h01C2, 16'h0384, 16'h05DC, 16'h0834,
    16'h0BB8, 16'h1068, 16'h1770, 16'h20D0, 16'h3840};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] data;
  } smp_ctl_t;

  typedef struct packed {
    logic jumperOut;
    logic [1:0] irqLevel;
    logic hostIrqEn;
    logic irqReq;
    logic fwIrqArmStatement;
    logic hsActive;
    logic hsEscErr;
  } smp_fw_t;

  typedef struct packed {
    logic txd;
    logic dtr;
    logic srts;
    logic drs;
    logic txClk;
  } smp_modem_t;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} smp_txst_t;
endpackage : smp_pkg

// ---- hdl/smp_fifo.sv ----
// smp_fifo: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module smp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_q, rdPtr_q;
  logic [AW:0] cnt_q, cnt_d;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign outData = mem[rdPtr_q];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else if (flush) begin
      cnt_q <= '0;
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      inReady <= cnt_d != (AW+1)'(D);
      outValid <= cnt_d != '0;
    end
  end

  // storage has no reset; entries are only read after being written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule : smp_fifo

// ---- hdl/smp_port.sv ----
// smp_port: serial modem port registers and character transmitter
`timescale 1ns/1ps
module smp_port #(
  parameter int unsigned CLK_HZ = smp_pkg::CLK_HZ_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // status and control register port
  input wire smp_pkg::smp_ctl_t ctlReq,
  output logic [15:0] rdData,
  output logic ctlErr,
  // characters to send
  input wire logic txValid,
  input wire logic [smp_pkg::DATA_W-1:0] txData,
  output logic txReady,
  // straps and firmware state
  input wire smp_pkg::smp_fw_t fwIn,
  // modem lines
  output smp_pkg::smp_modem_t modem
);
  import smp_pkg::*;

  logic [7:0] fmt_q;
  logic [3:0] baudIdx_q;
  logic softRst_q, brkPend_q, ctlErr_q;
  logic [15:0] rdData_q;
  smp_fw_t fw_q;
  smp_modem_t modem_q;
  smp_txst_t st_q;
  logic [DIV_W-1:0] divCnt_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic par_q;

  // register decode
  wire [7:0] wrByte = ctlReq.data[7:0];
  wire wrRst = ctlReq.wr && ctlReq.addr == REG_IDENT_RST;
  wire wrBrk = ctlReq.wr && ctlReq.addr == REG_IRQ_BRK;
  wire wrBaud = ctlReq.wr && ctlReq.addr == REG_BAUD;
  wire wrFmt = ctlReq.wr && ctlReq.addr == REG_FMT;
  wire unmapped = (ctlReq.wr || ctlReq.rd) && ctlReq.addr > REG_FMT;

  // rate table and rounding of a requested rate
  logic [DIV_W-1:0] divTab [16];
  logic [14:0] above;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_rate
      assign divTab[gi] = DIV_W'(CLK_HZ / RATE[gi]);
      if (gi < 15) begin : g_mid
        assign above[gi] = ctlReq.data >= RATE_MID[gi];
      end
    end
  endgenerate

  logic [3:0] roundIdx;
  // thermometer count picks the nearest rate
  always_comb begin
    roundIdx = 4'h0;
    for (int i = 0; i < 15; i++) begin
      roundIdx = roundIdx + 4'(above[i]);
    end
  end

  wire baudOk = ctlReq.data >= BAUD_MIN && ctlReq.data <= BAUD_MAX;
  // code 10 refused; sense codes 10 and 11 refused
  wire fmtOk = !wrByte[FMT_SENSE_LSB+1] && wrByte[FMT_HS_LSB+:2] != HS_BAD;
  // code 00 keeps the handshake setting
  wire [1:0] hsNew = wrByte[FMT_HS_LSB+:2] == HS_KEEP ? fmt_q[FMT_HS_LSB+:2] : wrByte[FMT_HS_LSB+:2];
  wire [7:0] fmtNew = {hsNew, wrByte[5:0]};
  wire errNow = (wrBaud && !baudOk) || (wrFmt && !fmtOk) || unmapped;

  // transmitter helpers
  wire [DIV_W-1:0] bitDiv = divTab[baudIdx_q];
  wire tick = divCnt_q == '0;
  wire fifoValid;
  wire [DATA_W-1:0] fifoData;
  wire brkGo = st_q == TX_IDLE && brkPend_q && !softRst_q;
  wire popGo = st_q == TX_IDLE && !brkPend_q && fifoValid && !softRst_q;
  // length 5..8 masks the unused upper bits
  wire [1:0] lenCode = fmt_q[FMT_LEN_LSB+:2];
  wire [7:0] lenMask = 8'hFF >> (2'h3 - lenCode);
  wire [3:0] lastBit = 4'(LEN_MIN + {2'h0, lenCode} - 4'h1);
  // odd sense inverts the even parity
  wire parNew = ^(fifoData & lenMask) ^ (fmt_q[FMT_SENSE_LSB+:2] == PAR_ODD);
  wire twoStop = fmt_q[FMT_STOP_BIT];
  wire busy = st_q != TX_IDLE || fifoValid || brkPend_q;

  // read data selection
  logic [15:0] rdMux;
  always_comb begin
    case (ctlReq.addr)
      // jumper flag rides on the top bit
      REG_IDENT_RST: rdMux = {8'h00, fw_q.jumperOut, IDENT_CODE};
      // enable, request, level, low nibble zero
      REG_IRQ_BRK: rdMux = {8'h00, fw_q.hostIrqEn, fw_q.irqReq, fw_q.irqLevel, 4'h0};
      REG_ACT: rdMux = {8'h00, 4'h0, fw_q.hsEscErr, fw_q.hsActive, fw_q.fwIrqArmStatement, busy};
      // the rate in use, always from the table
      REG_BAUD: rdMux = RATE[baudIdx_q];
      REG_FMT: rdMux = {8'h00, fmt_q};
      default: rdMux = 16'h0000;
    endcase
  end

  // status inputs sampled every cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fw_q <= '0;
    end else begin
      fw_q <= fwIn;
    end
  end

  // register answers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 16'h0000;
      ctlErr_q <= 1'b0;
    end else begin
      rdData_q <= ctlReq.rd ? rdMux : rdData_q;
      ctlErr_q <= errNow;
    end
  end

  // nonzero low byte resets the card on the next edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= wrRst && wrByte != 8'h00;
    end
  end

  // defaults after power-up and after a card reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fmt_q <= FMT_RST;
      baudIdx_q <= BAUD_IDX_RST;
      brkPend_q <= 1'b0;
    end else if (softRst_q) begin
      fmt_q <= FMT_RST;
      baudIdx_q <= BAUD_IDX_RST;
      brkPend_q <= 1'b0;
    end else begin
      // only the low byte of the format write is used
      if (wrFmt && fmtOk) begin
        fmt_q <= fmtNew;
      end
      if (wrBaud && baudOk) begin
        baudIdx_q <= roundIdx;
      end
      // a new break request wins over the take-up
      brkPend_q <= (brkPend_q && !brkGo) || (wrBrk && wrByte != 8'h00);
    end
  end

  // character transmitter, one bit per divider period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= TX_IDLE;
      modem_q.txd <= 1'b1;
      divCnt_q <= '0;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      par_q <= 1'b0;
      modem_q.dtr <= 1'b0;
      modem_q.srts <= 1'b0;
      modem_q.drs <= 1'b0;
      modem_q.txClk <= 1'b0;
    end else if (softRst_q) begin
      // a character in flight is cut off
      st_q <= TX_IDLE;
      modem_q.txd <= 1'b1;
      divCnt_q <= '0;
      bitCnt_q <= 4'h0;
      // not ready during a card reset
      modem_q.dtr <= 1'b0;
      modem_q.srts <= 1'b0;
      modem_q.drs <= baudIdx_q >= DRS_IDX;
      modem_q.txClk <= 1'b0;
    end else begin
      // one process owns the whole line struct, so no field has two drivers
      // ready whenever not in a card reset
      modem_q.dtr <= 1'b1;
      // ready to send while characters wait or go out
      modem_q.srts <= busy;
      // upper rate of a dual-rate modem from 2400 up
      modem_q.drs <= baudIdx_q >= DRS_IDX;
      // high in the first half of every bit time
      modem_q.txClk <= st_q != TX_IDLE && divCnt_q >= (bitDiv >> 1);
      divCnt_q <= tick ? bitDiv - DIV_W'(1) : divCnt_q - DIV_W'(1);
      case (st_q)
        TX_IDLE: begin
          divCnt_q <= bitDiv - DIV_W'(1);
          if (brkGo) begin
            // spacing held for more than a longest frame
            st_q <= TX_BRK;
            modem_q.txd <= 1'b0;
            bitCnt_q <= BRK_BITS - 4'h1;
          end else if (popGo) begin
            // low start bit opens the frame
            st_q <= TX_START;
            modem_q.txd <= 1'b0;
            shift_q <= fifoData & lenMask;
            par_q <= parNew;
          end
        end
        TX_START: begin
          if (tick) begin
            // data leaves least significant bit first
            st_q <= TX_DATA;
            modem_q.txd <= shift_q[0];
            shift_q <= shift_q >> 1;
            bitCnt_q <= lastBit;
          end
        end
        TX_DATA: begin
          if (tick) begin
            if (bitCnt_q != 4'h0) begin
              modem_q.txd <= shift_q[0];
              shift_q <= shift_q >> 1;
              bitCnt_q <= bitCnt_q - 4'h1;
            end else if (fmt_q[FMT_PEN_BIT]) begin
              st_q <= TX_PAR;
              modem_q.txd <= par_q;
            end else begin
              st_q <= TX_STOP;
              modem_q.txd <= 1'b1;
              bitCnt_q <= {3'h0, twoStop};
            end
          end
        end
        TX_PAR: begin
          if (tick) begin
            st_q <= TX_STOP;
            modem_q.txd <= 1'b1;
            bitCnt_q <= {3'h0, twoStop};
          end
        end
        TX_STOP: begin
          if (tick) begin
            if (bitCnt_q != 4'h0) begin
              bitCnt_q <= bitCnt_q - 4'h1;
            end else begin
              st_q <= TX_IDLE;
            end
          end
        end
        TX_BRK: begin
          if (tick) begin
            if (bitCnt_q != 4'h0) begin
              bitCnt_q <= bitCnt_q - 4'h1;
            end else begin
              // one mark bit before the line counts as idle again
              st_q <= TX_STOP;
              modem_q.txd <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= TX_IDLE;
          modem_q.txd <= 1'b1;
        end
      endcase
    end
  end

  // the fifo absorbs bursts from the host while a slow rate drains it
  smp_fifo #(
    .W(DATA_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rstn(rstn),
    .flush(softRst_q),
    .inValid(txValid),
    .inData(txData),
    .inReady(txReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(popGo)
  );

  assign rdData = rdData_q;
  assign ctlErr = ctlErr_q;
  assign modem = modem_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence rstCmd_s;
    wrRst && wrByte != 8'h00;
  endsequence
  sequence defaults_s;
    fmt_q == FMT_RST && baudIdx_q == BAUD_IDX_RST && !fifoValid;
  endsequence
  sequence brkStart_s;
    brkGo;
  endsequence
  sequence spacing_s;
    (!modem_q.txd && st_q == TX_BRK) [*8];
  endsequence

  resetCmd_a: assert property (rstCmd_s |=> softRst_q ##1 defaults_s)
    else $error("card reset did not restore defaults");
  resetZero_a: assert property (wrRst && wrByte == 8'h00 |=> !softRst_q)
    else $error("zero reset write acted");
  identRead_a: assert property (ctlReq.rd && ctlReq.addr == REG_IDENT_RST
    |=> rdData_q[6:0] == IDENT_CODE && rdData_q[IDENT_JMP_BIT] == $past(fw_q.jumperOut))
    else $error("ident read wrong");
  irqRead_a: assert property (ctlReq.rd && ctlReq.addr == REG_IRQ_BRK
    |=> rdData_q[3:0] == 4'h0 && rdData_q[IRQ_LVL_LSB+:2] == $past(fw_q.irqLevel)
    && rdData_q[IRQ_EN_BIT] == $past(fw_q.hostIrqEn))
    else $error("irq status read wrong");
  actRead_a: assert property (ctlReq.rd && ctlReq.addr == REG_ACT
    |=> rdData_q[7:4] == 4'h0 && rdData_q[ACT_ESC_BIT] == $past(fw_q.hsEscErr))
    else $error("activity read wrong");
  baudRead_a: assert property (ctlReq.rd && ctlReq.addr == REG_BAUD
    |=> rdData_q == RATE[$past(baudIdx_q)])
    else $error("baud readback not a table rate");
  baudRange_a: assert property (wrBaud && !baudOk && !softRst_q
    |=> ctlErr_q && baudIdx_q == $past(baudIdx_q))
    else $error("out of range baud accepted");
  fmtBad_a: assert property (wrFmt && !fmtOk && !softRst_q
    |=> ctlErr_q && fmt_q == $past(fmt_q))
    else $error("unsupported format accepted");
  hsKeep_a: assert property (wrFmt && fmtOk && wrByte[7:6] == HS_KEEP && !softRst_q
    |=> fmt_q[7:6] == $past(fmt_q[7:6]))
    else $error("no-op handshake code changed setting");
  breakLow_a: assert property (brkStart_s |=> spacing_s)
    else $error("break not spacing");
  startBit_a: assert property (popGo |=> !modem_q.txd && st_q == TX_START)
    else $error("start bit missing");
  stopHigh_a: assert property (st_q == TX_STOP |-> modem_q.txd)
    else $error("stop bit not marking");
endmodule : smp_port

// ---- tb/smp_modem_model.sv ----
// smp_modem_model: serial line receiver standing in for the modem
`timescale 1ns/1ps
module smp_modem_model (
  // clock and line
  input wire logic mclk,
  input wire logic txd,
  // expected frame shape
  input wire logic [3:0] nBits,
  input wire logic parEn,
  input wire logic [1:0] nStops,
  input wire logic [15:0] bitDiv,
  // last decoded frame: stop ok, parity, character
  output logic [9:0] rxWord,
  output int rxCount,
  // status lines toward the port
  output logic ringInd,
  output logic secCarrier
);
  // no call and no secondary carrier here
  assign ringInd = 1'b0;
  assign secCarrier = 1'b0;
  // start, data lsb first, parity, stops
  initial begin
    rxCount = 0;
    rxWord = 10'h000;
    forever begin
      @(negedge txd);
      // sample mid-bit so edge jitter of the port does not matter
      repeat (bitDiv / 2) @(posedge mclk);
      rxWord = 10'h200;
      for (int i = 0; i < nBits + parEn; i++) begin
        repeat (bitDiv) @(posedge mclk);
        rxWord[i == nBits ? 8 : i] = txd;
      end
      for (int i = 0; i < nStops; i++) begin
        repeat (bitDiv) @(posedge mclk);
        rxWord[9] = rxWord[9] & txd;
      end
      rxCount++;
    end
  end
endmodule : smp_modem_model

// ---- tb/smp_port_test.sv ----
// smp_port_test: self-checking bench for the serial modem port
`timescale 1ns/1ps
module smp_port_test;
  import smp_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  smp_ctl_t ctlReq = '0;
  logic [15:0] rdData;
  logic ctlErr;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txReady;
  smp_fw_t fwIn = '0;
  smp_modem_t modem;
  logic [3:0] nBits = 4'h8;
  logic parEn = 1'b0;
  logic [1:0] nStops = 2'h1;
  logic [15:0] bitDiv = 16'h0068;
  logic [9:0] rxWord;
  int rxCount;
  int clkRise = 0;
  int errors = 0;
  int tests_run = 0;
  logic [15:0] rd;
  logic [7:0] rb;
  logic errSeen;
  logic [15:0] expQ [$];

  always #2.5 mclk = ~mclk;
  always @(posedge modem.txClk) clkRise++;

  smp_port #(.CLK_HZ(1_000_000)) dut (.mclk(mclk), .rstn(rstn), .ctlReq(ctlReq), .rdData(rdData),
    .ctlErr(ctlErr), .txValid(txValid), .txData(txData), .txReady(txReady), .fwIn(fwIn), .modem(modem));
  smp_modem_model peer (.mclk(mclk), .txd(modem.txd), .nBits(nBits), .parEn(parEn), .nStops(nStops),
    .bitDiv(bitDiv), .rxWord(rxWord), .rxCount(rxCount), .ringInd(), .secCarrier());

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  always @(rxCount) begin
    if (expQ.size() > 0) begin
      check("received frame", {6'h00, rxWord}, expQ.pop_front());
    end
  end

  task automatic access(input logic wr, input logic [3:0] addr, input logic [15:0] data);
    @(posedge mclk);
    ctlReq <= '{wr, !wr, addr, data};
    @(posedge mclk);
    ctlReq <= '0;
    #1;
    rd = rdData;
    rb = rdData[7:0];
    errSeen = ctlErr;
  endtask : access

  task automatic reg_step(input logic [3:0] addr, input logic [15:0] wdat, input logic [15:0] exp,
    input logic bad);
    access(1'b1, addr, wdat);
    check("write refused", errSeen, bad);
    access(1'b0, addr, 16'h0000);
    check("readback", addr == REG_BAUD ? rd : {8'h00, rb}, exp);
  endtask : reg_step

  task automatic send(input logic [7:0] d);
    int n = 0;
    @(posedge mclk);
    txValid <= 1'b1;
    txData <= d;
    #1;
    while (txReady !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("send wait", 16'(n < 20000), 16'h0001);
    if (n == 20000) test_done;
    @(posedge mclk);
    txValid <= 1'b0;
  endtask : send

  task automatic wait_drain;
    int n = 0;
    while (expQ.size() > 0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    check("drain wait", 16'(n < 20000), 16'h0001);
    if (n == 20000) test_done;
    repeat (3 * bitDiv) @(posedge mclk);
  endtask : wait_drain

  task automatic test_reset;
    access(1'b0, REG_IDENT_RST, 16'h0000);
    check("ident", rb, {1'b0, IDENT_CODE});
    @(posedge mclk);
    fwIn.jumperOut <= 1'b1;
    access(1'b0, REG_IDENT_RST, 16'h0000);
    check("ident jumper", rb, {1'b1, IDENT_CODE});
    access(1'b0, REG_FMT, 16'h0000);
    check("format default", rb, FMT_RST);
    access(1'b0, REG_BAUD, 16'h0000);
    check("baud default", rd, 16'h2580);
    check("lines idle", {11'h000, modem}, 16'h001A);
    check("room", txReady, 1'b1);
    $display("test reset finished");
  endtask : test_reset

  task automatic test_status;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      fwIn <= '{jumperOut: 1'b0, irqLevel: 2'(i), hostIrqEn: i[0], irqReq: i[1],
        fwIrqArmStatement: !i[0], hsActive: i[1], hsEscErr: i[0]};
      access(1'b0, REG_IRQ_BRK, 16'h0000);
      check("irq state", rb, {i[0], i[1], 2'(i), 4'h0});
      access(1'b0, REG_ACT, 16'h0000);
      check("activity", rb, {4'h0, i[0], i[1], !i[0], 1'b0});
    end
    $display("test status finished");
  endtask : test_status

  task automatic test_regs;
    reg_step(REG_BAUD, 16'h0018, 16'h2580, 1'b1);
    reg_step(REG_BAUD, 16'h0019, 16'h0032, 1'b0);
    check("rate select low", modem.drs, 1'b0);
    reg_step(REG_BAUD, 16'h7081, 16'h0032, 1'b1);
    reg_step(REG_BAUD, 16'h7080, 16'h4B00, 1'b0);
    reg_step(REG_BAUD, 16'h0833, 16'h0708, 1'b0);
    check("rate select 1800", modem.drs, 1'b0);
    reg_step(REG_BAUD, 16'h0834, 16'h0960, 1'b0);
    check("rate select 2400", modem.drs, 1'b1);
    reg_step(REG_FMT, 16'h0023, 16'h00C3, 1'b1);
    reg_step(REG_FMT, 16'h0083, 16'h00C3, 1'b1);
    reg_step(REG_FMT, 16'h0143, 16'h0043, 1'b0);
    reg_step(REG_FMT, 16'h0003, 16'h0043, 1'b0);
    reg_step(REG_FMT, 16'h00C3, 16'h00C3, 1'b0);
    access(1'b1, 4'h5, 16'h0001);
    check("unmapped write", errSeen, 1'b1);
    access(1'b1, REG_BAUD, 16'h4B00);
    bitDiv = 16'h0034;
    $display("test regs finished");
  endtask : test_regs

  task automatic test_frames;
    logic [7:0] fmt [4] = '{8'hC8, 8'hDD, 8'hCE, 8'hC3};
    logic [7:0] ch;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, REG_FMT, {8'h00, fmt[i]});
      nBits = 4'(fmt[i][1:0]) + LEN_MIN;
      parEn = fmt[i][3];
      nStops = 2'(fmt[i][2]) + 2'h1;
      ch = 8'hA5 & (8'hFF >> (4'h8 - nBits));
      // odd sense needs the parity bit to make the count of ones odd
      expQ.push_back({7'h01, parEn & (^ch ^ !fmt[i][4]), ch});
      clkRise = 0;
      send(8'hA5);
      repeat (2 * bitDiv) @(posedge mclk);
      check("srts busy", modem.srts, 1'b1);
      access(1'b0, REG_ACT, 16'h0000);
      check("transfer busy", rb[ACT_XFER_BIT], 1'b1);
      wait_drain;
      check("bit clocks", 16'(clkRise), 16'(1 + nBits + parEn + nStops));
      check("srts idle", {modem.srts, modem.txd}, 2'h1);
    end
    $display("test frames finished");
  endtask : test_frames

  task automatic test_fifo;
    for (int i = 0; i < 10; i++) begin
      expQ.push_back({8'h02, 8'(8'h30 + i)});
      send(8'(8'h30 + i));
      if (i == 8) begin
        @(posedge mclk);
        #1;
        check("fifo full", txReady, 1'b0);
      end
    end
    wait_drain;
    $display("test fifo finished");
  endtask : test_fifo

  task automatic test_break;
    int n = 0;
    access(1'b1, REG_IRQ_BRK, 16'h0000);
    repeat (4 * bitDiv) @(posedge mclk);
    check("no break on zero", modem.txd, 1'b1);
    access(1'b1, REG_IRQ_BRK, 16'h0040);
    while (modem.txd !== 1'b0 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("break start", 16'(n < 100), 16'h0001);
    if (n == 100) test_done;
    n = 0;
    while (modem.txd === 1'b0 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("break length", 16'(n), 16'(BRK_BITS * bitDiv));
    repeat (3 * bitDiv) @(posedge mclk);
    $display("test break finished");
  endtask : test_break

  task automatic test_card_reset;
    int n = 0;
    int cnt;
    reg_step(REG_FMT, 16'h00CA, 16'h00CA, 1'b0);
    access(1'b1, REG_IDENT_RST, 16'h0100);
    access(1'b0, REG_FMT, 16'h0000);
    check("zero low byte", rb, 8'hCA);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    repeat (3 * bitDiv) @(posedge mclk);
    access(1'b1, REG_IDENT_RST, 16'h0080);
    while (modem.dtr !== 1'b0 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("dtr drop", modem.dtr, 1'b0);
    @(posedge mclk);
    #1;
    check("lines after reset", {11'h000, modem}, 16'h001A);
    check("fifo flushed", txReady, 1'b1);
    access(1'b0, REG_FMT, 16'h0000);
    check("format restored", rb, FMT_RST);
    access(1'b0, REG_BAUD, 16'h0000);
    check("baud restored", rd, 16'h2580);
    // a cut frame may still decode once; flushed characters must not follow
    repeat (1500) @(posedge mclk);
    cnt = rxCount;
    repeat (3000) @(posedge mclk);
    check("no frames after flush", 16'(rxCount - cnt), 16'h0000);
    $display("test card reset finished");
  endtask : test_card_reset

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    test_reset;
    test_status;
    test_regs;
    test_frames;
    test_fifo;
    test_break;
    test_card_reset;
    test_done;
  end

  initial begin
    #400000;
    check("run time bound", 16'h0000, 16'h0001);
    test_done;
  end
endmodule : smp_port_test
